// ==== hdl/sfp_pkg.sv ====
package sfp_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STAT_OFS   = 8'h04;
   localparam logic [7:0] TXD_OFS    = 8'h08;
   localparam logic [7:0] RXD_OFS    = 8'h0C;
   // control field positions
   localparam int CTRL_QE_POS   = 0;
   localparam int CTRL_LW_POS   = 1;
   localparam int CTRL_BUSY_POS = 3;
   localparam int CTRL_CMP_POS  = 4;
   localparam int CTRL_BSZ_POS  = 5;
   localparam int CTRL_TB_POS   = 6;
   localparam int CTRL_BP_POS   = 7;
   localparam logic [9:0] CTRL_RST = 10'h000;
   localparam logic [1:0] AXI_OKAY   = 2'h0;
   localparam logic [1:0] AXI_SLVERR = 2'h2;
   // transfer widths
   typedef enum logic [1:0] {SFP_X1, SFP_X2, SFP_X4} sfp_width_t;
   // protection settings
   typedef struct packed {
      logic       cmp;
      logic       bsz;
      logic       tb;
      logic [2:0] bp;
   } sfp_prot_t;
endpackage

// ==== hdl/sfp_fifo.sv ====
`timescale 1ns/10ps
module sfp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,      // clock
   input  wire logic             rstN,     // reset
   input  wire logic             inValid,  // write valid
   output      logic             inReady,  // not full
   input  wire logic [WIDTH-1:0] inData,   // write data
   output      logic             outValid, // not empty
   input  wire logic             outReady, // read accept
   output      logic [WIDTH-1:0] outData   // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp;
   logic [AW:0]      rp;
   logic [AW:0]      next_wp;
   logic [AW:0]      next_rp;
   // pointer math, extra bit tells full from empty
   always_comb begin
      inReady  = (wp - rp) != (AW+1)'(DEPTH);
      outValid = wp != rp;
      next_wp  = (inValid && inReady) ? wp + 1'b1 : wp;
      next_rp  = (outValid && outReady) ? rp + 1'b1 : rp;
   end
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wp <= '0;
         rp <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
      end
   end
   // storage has no reset
   always_ff @(posedge clk) begin
      if (inValid && inReady) begin
         mem[wp[AW-1:0]] <= inData;
      end
   end
   assign outData = mem[rp[AW-1:0]];
endmodule

// ==== hdl/sfp_pins.sv ====
`timescale 1ns/10ps
module sfp_pins (
   input  wire logic        ref_clk,   // 50 MHz system clock
   input  wire logic        nrst,      // async reset, active low
   input  wire logic        selN,      // chip select pin
   input  wire logic        sck,       // serial clock pin
   input  wire logic [3:0]  dIn,       // data lines 3..0 in
   output      logic [3:0]  dOut,      // data lines 3..0 out
   output      logic [3:0]  dOe,       // data lines 3..0 enable
   output      logic        standby,   // deselected and idle
   output      logic        arrayLock, // hardware array lock
   input  wire logic [31:0] awaddr,    // axi write address
   input  wire logic        awvalid,   // axi
   output      logic        awready,   // axi
   input  wire logic [31:0] wdata,     // axi
   input  wire logic [3:0]  wstrb,     // axi
   input  wire logic        wvalid,    // axi
   output      logic        wready,    // axi
   output      logic [1:0]  bresp,     // axi
   output      logic        bvalid,    // axi
   input  wire logic        bready,    // axi
   input  wire logic [31:0] araddr,    // axi read address
   input  wire logic        arvalid,   // axi
   output      logic        arready,   // axi
   output      logic [31:0] rdata,     // axi
   output      logic [1:0]  rresp,     // axi
   output      logic        rvalid,    // axi
   input  wire logic        rready     // axi
);
   logic [1:0] rsync;
   logic       rstN;
   // reset release through two flops
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) rsync <= 2'h0;
      else rsync <= {rsync[0], 1'b1};
   end
   assign rstN = rsync[1];

   // pin synchronisers; stage one feeds only stage two
   logic [5:0] s1;
   logic [5:0] s2;
   logic       sckQ;
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         s1   <= 6'h01;
         s2   <= 6'h01;
         sckQ <= 1'b0;
      end else begin
         s1   <= {dIn, sck, selN};
         s2   <= s1;
         sckQ <= s2[1];
      end
   end
   logic selNs;
   logic sckRise;
   logic sckFall;
   logic [3:0] dS;
   assign selNs   = s2[0];
   assign dS      = s2[5:2];
   assign sckRise = s2[1] && !sckQ;
   assign sckFall = !s2[1] && sckQ;

   // control register fields
   logic [9:0]  ctrl;
   logic        quadEn;
   logic        wpN;
   sfp_pkg::sfp_prot_t prot;
   sfp_pkg::sfp_width_t width;
   assign quadEn = ctrl[sfp_pkg::CTRL_QE_POS];
   assign width  = sfp_pkg::sfp_width_t'(ctrl[sfp_pkg::CTRL_LW_POS +: 2]);
   // fields sit in reverse order in ctrl, so gather them one by one
   assign prot   = '{cmp: ctrl[sfp_pkg::CTRL_CMP_POS],
                     bsz: ctrl[sfp_pkg::CTRL_BSZ_POS],
                     tb:  ctrl[sfp_pkg::CTRL_TB_POS],
                     bp:  ctrl[sfp_pkg::CTRL_BP_POS +: 3]};
   // pin is write-protect only when quad lines are off
   assign wpN    = quadEn ? 1'b1 : dS[2];
   // lock needs protect pin low and a nonzero bp level or cmp set
   assign arrayLock = !wpN && ((prot.bp != 3'h0) || prot.cmp);

   // link shifter: rx byte into fifo, tx bits from fifo
   logic [7:0] rxSh, next_rxSh;
   logic [3:0] rxCnt, next_rxCnt;
   logic [7:0] txSh, next_txSh;
   logic [3:0] txCnt, next_txCnt;
   logic [3:0] dOutR, next_dOutR;
   logic [3:0] dOeR, next_dOeR;
   logic       rxPush;
   logic       txPop;
   logic       rxRdy;
   logic [7:0] txHead;
   logic       txHave;
   logic [2:0] step;
   always_comb begin
      step = (width == sfp_pkg::SFP_X4 && quadEn) ? 3'h4 :
             (width == sfp_pkg::SFP_X2) ? 3'h2 : 3'h1;
   end
   always_comb begin
      next_rxSh  = rxSh;
      next_rxCnt = rxCnt;
      next_txSh  = txSh;
      next_txCnt = txCnt;
      next_dOutR = dOutR;
      next_dOeR  = dOeR;
      rxPush     = 1'b0;
      txPop      = 1'b0;
      if (selNs) begin
         // deselected: drop frame state, float outputs
         next_rxCnt = 4'h0;
         next_txCnt = 4'h0;
         next_dOeR  = 4'h0;
      end else begin
         if (sckRise && width == sfp_pkg::SFP_X1 && rxRdy) begin
            next_rxSh  = {rxSh[6:0], dS[0]};
            next_rxCnt = rxCnt + 4'h1;
            if (rxCnt == 4'h7) begin
               rxPush     = 1'b1;
               next_rxCnt = 4'h0;
            end
         end
         if (sckFall) begin
            // a byte is fetched when the previous one is spent
            if (txCnt == 4'h0 && txHave) begin
               txPop      = 1'b1;
               next_txSh  = txHead;
               next_txCnt = 4'h8;
            end
            if (txCnt != 4'h0 || txHave) begin
               if (step == 3'h4) begin
                  next_dOutR = (txCnt == 4'h0) ? txHead[7:4] : txSh[7:4];
                  next_dOeR  = 4'hF;
               end else if (step == 3'h2) begin
                  next_dOutR = {2'h0,
                     (txCnt == 4'h0) ? txHead[7:6] : txSh[7:6]};
                  next_dOeR  = 4'h3;
               end else begin
                  next_dOutR = {2'h0,
                     (txCnt == 4'h0) ? txHead[7] : txSh[7], 1'b0};
                  next_dOeR  = 4'h2;
               end
               if (txCnt == 4'h0) begin
                  next_txSh  = txHead << step;
                  next_txCnt = 4'h8 - {1'b0, step};
               end else begin
                  next_txSh  = txSh << step;
                  next_txCnt = txCnt - {1'b0, step};
               end
            end
         end
      end
   end
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         rxSh  <= 8'h00;
         rxCnt <= 4'h0;
         txSh  <= 8'h00;
         txCnt <= 4'h0;
         dOutR <= 4'h0;
         dOeR  <= 4'h0;
      end else begin
         rxSh  <= next_rxSh;
         rxCnt <= next_rxCnt;
         txSh  <= next_txSh;
         txCnt <= next_txCnt;
         dOutR <= next_dOutR;
         dOeR  <= next_dOeR;
      end
   end
   assign dOut = dOutR;
   assign dOe  = dOeR;

   // fifos: rx toward software, tx from software
   logic       rxValid;
   logic [7:0] rxHead;
   logic       rxPop;
   logic       txPush;
   logic       txRdy;
   sfp_fifo #(.WIDTH(8), .DEPTH(16)) uRx (
      .clk(ref_clk), .rstN(rstN), .inValid(rxPush), .inReady(rxRdy),
      .inData({rxSh[6:0], dS[0]}), .outValid(rxValid),
      .outReady(rxPop), .outData(rxHead));
   sfp_fifo #(.WIDTH(8), .DEPTH(16)) uTx (
      .clk(ref_clk), .rstN(rstN), .inValid(txPush), .inReady(txRdy),
      .inData(wdata[7:0]), .outValid(txHave),
      .outReady(txPop), .outData(txHead));

   // axi-lite slave: both channels taken together, one cycle answer
   logic        bvR, next_bvR;
   logic        rvR, next_rvR;
   logic [1:0]  brR, next_brR;
   logic [1:0]  rrR, next_rrR;
   logic [31:0] rdR, next_rdR;
   logic [9:0]  next_ctrl;
   logic        wrGo;
   logic        rdGo;
   logic        busy;
   assign busy = ctrl[sfp_pkg::CTRL_BUSY_POS];
   assign wrGo = awvalid && wvalid && !bvR;
   assign rdGo = arvalid && !rvR;
   assign awready = wrGo;
   assign wready  = wrGo;
   assign arready = rdGo;
   always_comb begin
      next_ctrl = ctrl;
      next_bvR  = bvR && !bready;
      next_brR  = brR;
      next_rvR  = rvR && !rready;
      next_rrR  = rrR;
      next_rdR  = rdR;
      txPush    = 1'b0;
      rxPop     = 1'b0;
      if (wrGo) begin
         next_bvR = 1'b1;
         next_brR = sfp_pkg::AXI_OKAY;
         case (awaddr[7:0])
            sfp_pkg::CTRL_OFS: begin
               // control writes refused while protect pin is low
               if (!wpN) next_brR = sfp_pkg::AXI_SLVERR;
               else if (wstrb[0] && wstrb[1]) next_ctrl = wdata[9:0];
            end
            sfp_pkg::TXD_OFS: begin
               txPush = wstrb[0] && txRdy;
               if (!txRdy) next_brR = sfp_pkg::AXI_SLVERR;
            end
            default: next_brR = sfp_pkg::AXI_SLVERR;
         endcase
      end
      // self-timed cycle flag clears only by software, not by select
      if (rdGo) begin
         next_rvR = 1'b1;
         next_rrR = sfp_pkg::AXI_OKAY;
         case (araddr[7:0])
            sfp_pkg::CTRL_OFS: next_rdR = {22'h0, ctrl};
            sfp_pkg::STAT_OFS: next_rdR = {26'h0, arrayLock, !wpN,
                                  !txRdy, rxValid, selNs, standby};
            sfp_pkg::RXD_OFS: begin
               next_rdR = {23'h0, rxValid, rxHead};
               rxPop    = rxValid;
            end
            default: begin
               next_rdR = 32'h0;
               next_rrR = sfp_pkg::AXI_SLVERR;
            end
         endcase
      end
   end
   always_ff @(posedge ref_clk or negedge rstN) begin
      if (!rstN) begin
         ctrl <= sfp_pkg::CTRL_RST;
         bvR  <= 1'b0;
         rvR  <= 1'b0;
         brR  <= sfp_pkg::AXI_OKAY;
         rrR  <= sfp_pkg::AXI_OKAY;
         rdR  <= 32'h0;
      end else begin
         ctrl <= next_ctrl;
         bvR  <= next_bvR;
         rvR  <= next_rvR;
         brR  <= next_brR;
         rrR  <= next_rrR;
         rdR  <= next_rdR;
      end
   end
   // standby only when deselected and no self-timed cycle runs
   assign standby = selNs && !busy;
   assign bvalid = bvR;
   assign bresp  = brR;
   assign rvalid = rvR;
   assign rresp  = rrR;
   assign rdata  = rdR;

   chk_desel_float: assert property (@(posedge ref_clk) disable iff (!rstN)
      $rose(selNs) |=> dOe == 4'h0) else $error("outputs not released");
   chk_busy_hold: assert property (@(posedge ref_clk) disable iff (!rstN)
      (selNs && busy) |-> !standby) else $error("standby while busy");
   chk_no_rx_desel: assert property (@(posedge ref_clk) disable iff (!rstN)
      selNs |-> !rxPush) else $error("input taken deselected");
   chk_wp_reject: assert property (@(posedge ref_clk) disable iff (!rstN)
      (wrGo && awaddr[7:0] == sfp_pkg::CTRL_OFS && !wpN) |=>
      ctrl == $past(ctrl)) else $error("protected write landed");
   chk_oe_fall: assert property (@(posedge ref_clk) disable iff (!rstN)
      (!selNs && !$past(selNs) && dOe != $past(dOe)) |-> $past(sckFall))
      else $error("output moved off falling edge");
   chk_quad_lines: assert property (@(posedge ref_clk) disable iff (!rstN)
      dOe[3] |-> quadEn) else $error("line 3 driven without quad");
   chk_lock_form: assert property (@(posedge ref_clk) disable iff (!rstN)
      quadEn |-> !arrayLock) else $error("lock with quad pin");
   chk_bresp_one: assert property (@(posedge ref_clk) disable iff (!rstN)
      wrGo |=> bvalid) else $error("write not answered");
endmodule

// ==== dv/sfp_host.sv ====
`timescale 1ns/10ps
// host controller model; its serial clock runs only inside send and recv
module sfp_host (
   output      logic       selN,   // select, low active
   output      logic       sck,    // serial clock, idle low
   output      logic [3:0] dLine,  // resolved data lines
   output      logic [3:0] oeSeen, // device enables seen in a read
   input  wire logic [3:0] dOut,   // device drive
   input  wire logic [3:0] dOe     // device enable
);
   logic [3:0] hostD;
   logic [3:0] hostOe;
   initial begin
      selN = 1'b1;
      sck = 1'b0;
      hostD = 4'h0;
      hostOe = 4'h0;
      oeSeen = 4'h0;
   end
   // lines 2 and 3 have pull-ups; released 0 and 1 show the inverse
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         dLine[i] = dOe[i] ? dOut[i] : hostOe[i] ? hostD[i] :
                    (i > 1) ? 1'b1 : ~dOut[i];
      end
   end
   // write-protect is active low, so high means let the pull-up win
   task automatic set_wp(input logic lvl);
      #5 hostOe[2] = ~lvl;
   endtask
   // one byte in, msb first; sel low clocks it without a select
   task automatic send(input logic [7:0] b, input logic sel);
      #5 selN = ~sel;
      hostOe[0] = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         hostD[0] = b[i];
         #80 sck = 1'b1;
         #80 sck = 1'b0;
      end
      #80 selN = 1'b1;
      hostOe[0] = 1'b0;
      #160;
   endtask
   // lead clock lets the device drive first; sampled late in high phase
   task automatic recv(input int w, output logic [7:0] b);
      #5 hostOe[1:0] = 2'b00;
      oeSeen = 4'h0;
      b = 8'h00;
      selN = 1'b0;
      for (int n = -w; n < 8; n += w) begin
         #80 sck = 1'b1;
         #70 oeSeen = oeSeen | dOe;
         b = (w == 1) ? {b[6:0], dLine[1]} :
             (w == 2) ? {b[5:0], dLine[1:0]} : {b[3:0], dLine};
         #10 sck = 1'b0;
      end
      #80 selN = 1'b1;
      #160;
   endtask
endmodule

// ==== dv/tb_sfp_pins.sv ====
`timescale 1ns/10ps
module tb_sfp_pins;
   logic        ref_clk, nrst, selN, sck, standby, arrayLock;
   logic [3:0]  dLine, oeSeen, dOut, dOe, wstrb;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   logic [7:0]  got;
   int          mismatches, samples_checked, cycles;
   int          wid[3] = '{1, 2, 4};
   logic [31:0] ctl[3] = '{32'h0, 32'h2, 32'h5};
   logic [7:0]  pat[3] = '{8'h3C, 8'hA6, 8'h5B};
   logic [31:0] oes[3] = '{32'h2, 32'h3, 32'hF};

   sfp_pins sfp_pins_i (.ref_clk(ref_clk), .nrst(nrst), .selN(selN),
      .sck(sck), .dIn(dLine), .dOut(dOut), .dOe(dOe), .standby(standby),
      .arrayLock(arrayLock), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   sfp_host sfp_host_i (.selN(selN), .sck(sck), .dLine(dLine),
      .oeSeen(oeSeen), .dOut(dOut), .dOe(dOe));

   always #10 ref_clk = ~ref_clk;

   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, e);
      samples_checked++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask

   // address and data offered together, each dropped when taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
      @(posedge ref_clk);
      awaddr <= {24'h0, a};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
      @(posedge ref_clk);
      araddr <= {24'h0, a};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      chk("rdata", rdata, e);
      chk("rresp", 32'(rresp), 32'(er));
   endtask

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         end_sim();
      end
   end

   initial begin
      ref_clk = 1'b0;
      nrst = 1'b0;
      wstrb = 4'hF;
      {awaddr, wdata, araddr} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      repeat (16) @(posedge ref_clk);
      nrst <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rdc(sfp_pkg::CTRL_OFS, 32'h0, sfp_pkg::AXI_OKAY);
      rdc(sfp_pkg::STAT_OFS, 32'h3, sfp_pkg::AXI_OKAY);
      chk("oe", 32'(dOe), 32'h0);
      rdc(8'h10, 32'h0, sfp_pkg::AXI_SLVERR);
      axw(sfp_pkg::CTRL_OFS, 32'h280, sfp_pkg::AXI_OKAY);
      sfp_host_i.set_wp(1'b0);
      repeat (4) @(posedge ref_clk);
      chk("lock", 32'(arrayLock), 32'h1);
      rdc(sfp_pkg::STAT_OFS, 32'h33, sfp_pkg::AXI_OKAY);
      axw(sfp_pkg::CTRL_OFS, 32'h0, sfp_pkg::AXI_SLVERR);
      rdc(sfp_pkg::CTRL_OFS, 32'h280, sfp_pkg::AXI_OKAY);
      sfp_host_i.set_wp(1'b1);
      // pin passes two flops before the write gate sees it released
      repeat (4) @(posedge ref_clk);
      axw(sfp_pkg::CTRL_OFS, 32'h281, sfp_pkg::AXI_OKAY);
      sfp_host_i.set_wp(1'b0);
      repeat (4) @(posedge ref_clk);
      chk("lock", 32'(arrayLock), 32'h0);
      axw(sfp_pkg::CTRL_OFS, 32'h0, sfp_pkg::AXI_OKAY);
      sfp_host_i.set_wp(1'b1);
      sfp_host_i.send(8'hA5, 1'b0);
      rdc(sfp_pkg::STAT_OFS, 32'h3, sfp_pkg::AXI_OKAY);
      sfp_host_i.send(8'hA5, 1'b1);
      rdc(sfp_pkg::RXD_OFS, 32'h1A5, sfp_pkg::AXI_OKAY);
      axw(sfp_pkg::CTRL_OFS, 32'h8, sfp_pkg::AXI_OKAY);
      rdc(sfp_pkg::STAT_OFS, 32'h2, sfp_pkg::AXI_OKAY);
      axw(sfp_pkg::CTRL_OFS, 32'h0, sfp_pkg::AXI_OKAY);
      chk("standby", 32'(standby), 32'h1);
      // one byte out in each width, line enables gathered by the host
      for (int k = 0; k < 3; k++) begin
         axw(sfp_pkg::CTRL_OFS, ctl[k], sfp_pkg::AXI_OKAY);
         axw(sfp_pkg::TXD_OFS, {24'h0, pat[k]}, sfp_pkg::AXI_OKAY);
         sfp_host_i.recv(wid[k], got);
         chk("txd", 32'(got), 32'(pat[k]));
         chk("oe", 32'(oeSeen), oes[k]);
         chk("oe", 32'(dOe), 32'h0);
      end
      // the x1 read frame clocked in the released line 0, all ones
      rdc(sfp_pkg::RXD_OFS, 32'h1FF, sfp_pkg::AXI_OKAY);
      // fill the transmit queue, then one more must be refused
      for (int k = 0; k < 16; k++) begin
         axw(sfp_pkg::TXD_OFS, 32'(k), sfp_pkg::AXI_OKAY);
      end
      axw(sfp_pkg::TXD_OFS, 32'h77, sfp_pkg::AXI_SLVERR);
      rdc(sfp_pkg::STAT_OFS, 32'hB, sfp_pkg::AXI_OKAY);
      end_sim();
   end
endmodule
